// *** core/multiphase_pwm_interleave_sampler.sv ***
// Interleaved multi-phase output timing with forced off-time and per-channel sample-and-hold.
//
// Function
// - Every phase offset is derived from the active channel count.
// - One switching cycle is the span between successive channel-1 falling edges.
// - Each cycle starts when channel 1 is driven low.
// - With four channels, falling edges are spaced a quarter cycle apart.
// - With phase 3 tied high, two channels run and channel 2 falls half a cycle later.
// - With only phase 4 tied high, three channels run spaced by one third cycle.
// - After each falling edge the output stays low at least one third cycle.
// - Each channel's current sample starts at its falling edge.
// - The sample window lasts one third of the switching period.
// - Each held sample stands for one full cycle until replaced.
module multiphase_pwm_interleave_sampler #(
   parameter int unsigned PERIOD_W = pwm_interleave_pkg::PERIOD_W,
   parameter int unsigned CUR_W    = pwm_interleave_pkg::CUR_W
) (
   input  wire logic                ref_clk,            // 100 MHz system clock.
   input  wire logic                reset_n,            // Asynchronous reset, active low.
   input  wire logic [PERIOD_W-1:0] freq_set_input,     // Cycle period in clocks.
   input  wire logic [3:0]          phaseDemand,        // Pulse request per phase, high = on.
   input  wire logic                phase3TiedHigh,     // Phase 3 pin read high at power up.
   input  wire logic                phase4TiedHigh,     // Phase 4 pin read high at power up.
   input  wire logic [4*CUR_W-1:0]  sensed_current,     // Live sensed current, four channels.
   output logic [3:0]               phaseOut,           // Phase 1..4 drive, bit 0 is phase 1.
   output logic [3:0]               phaseOutEn,         // Output enable per phase pin.
   output logic [2:0]               activeChannels,     // Active channel count.
   output logic                     cycleStart,         // Pulse when channel 1 falls.
   output logic [3:0]               sampleWindow,       // Sample window open per channel.
   output logic [4*CUR_W-1:0]       heldCurrent,        // Held samples for balance and protection.
   output logic [3:0]               heldValid           // New held sample pulse per channel.
);
   logic [PERIOD_W-1:0] period_q;
   logic [PERIOD_W-1:0] cnt_q;
   logic [1:0]          mode_q;
   logic                modeTaken_q;
   logic [PERIOD_W-1:0] offTime;
   logic [PERIOD_W-1:0] spacing;
   logic [3:0]          termHit;
   logic [PERIOD_W-1:0] offCnt_q [4];
   logic [3:0]          fall;
   logic [PERIOD_W-1:0] lowRun_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Channel count strap, caught once after reset release.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q      <= pwm_interleave_pkg::MODE_FOUR;
         modeTaken_q <= 1'b0;
      end else if (!modeTaken_q) begin
         modeTaken_q <= 1'b1;
         if (phase3TiedHigh) begin
            mode_q <= pwm_interleave_pkg::MODE_TWO;
         end else if (phase4TiedHigh) begin
            mode_q <= pwm_interleave_pkg::MODE_THREE;
         end else begin
            mode_q <= pwm_interleave_pkg::MODE_FOUR;
         end
      end
   end

   // Count of active channels decoded from the strap mode.
   always_comb begin
      unique case (mode_q)
         pwm_interleave_pkg::MODE_TWO:   activeChannels = pwm_interleave_pkg::CH_TWO;
         pwm_interleave_pkg::MODE_THREE: activeChannels = pwm_interleave_pkg::CH_THREE;
         default:                        activeChannels = pwm_interleave_pkg::CH_FOUR;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Free-running cycle counter; the period reloads only at a cycle boundary.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q    <= '0;
         period_q <= PERIOD_W'(pwm_interleave_pkg::DEFAULT_PERIOD);
      end else if (cnt_q >= period_q - 1'b1) begin
         cnt_q    <= '0;
         period_q <= (freq_set_input < pwm_interleave_pkg::MIN_PERIOD) ?
                     PERIOD_W'(pwm_interleave_pkg::MIN_PERIOD) : freq_set_input;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // Edge spacing and forced off-time as fractions of the period.
   assign spacing = PERIOD_W'(period_q / activeChannels);
   assign offTime = PERIOD_W'((period_q + 2'd2) / pwm_interleave_pkg::OFF_DIVISOR);

   ////////////////////////////////////////////////////////////////////////////////
   // Per-channel termination, off-time hold and output drive.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_ch
         logic chActive;
         assign chActive    = (gi < activeChannels);
         assign termHit[gi] = chActive && (cnt_q == PERIOD_W'(spacing * gi));
         assign fall[gi]    = termHit[gi] && phaseOut[gi];

         // Off counter: loaded at termination, output forced low while it runs.
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               offCnt_q[gi] <= '0;
            end else if (termHit[gi]) begin
               offCnt_q[gi] <= offTime;
            end else if (offCnt_q[gi] != '0) begin
               offCnt_q[gi] <= offCnt_q[gi] - 1'b1;
            end
         end

         // Output goes low at termination and may rise only after the off-time.
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               phaseOut[gi] <= 1'b0;
            end else if (termHit[gi]) begin
               phaseOut[gi] <= 1'b0;
            end else if (offCnt_q[gi] > 1) begin
               phaseOut[gi] <= 1'b0;
            end else begin
               phaseOut[gi] <= chActive && modeTaken_q && phaseDemand[gi];
            end
         end

         assign phaseOutEn[gi] = chActive && modeTaken_q;

         phase_sample_hold #(.CUR_W(CUR_W), .PERIOD_W(PERIOD_W)) u_sh (
            .ref_clk     (ref_clk),
            .reset_n     (reset_n),
            .fallPulse   (termHit[gi]),
            .windowLen   (offTime),
            .sensed      (sensed_current[gi*CUR_W +: CUR_W]),
            .sampling    (sampleWindow[gi]),
            .heldCurrent (heldCurrent[gi*CUR_W +: CUR_W]),
            .heldValid   (heldValid[gi])
         );
      end
   endgenerate

   assign cycleStart = termHit[0];

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   property p_cycle_anchor;
      @(posedge ref_clk) disable iff (!reset_n)
      (cnt_q >= period_q - 1'b1) |=> termHit[0];
   endproperty
   a_cycle_anchor: assert property (p_cycle_anchor) else $error("cycle not anchored");

   property p_low_after_term;
      @(posedge ref_clk) disable iff (!reset_n)
      termHit[0] |=> !phaseOut[0];
   endproperty
   a_low_after_term: assert property (p_low_after_term) else $error("ch1 not low");

   property p_forced_off;
      @(posedge ref_clk) disable iff (!reset_n)
      (offCnt_q[1] > 1) |=> !phaseOut[1];
   endproperty
   a_forced_off: assert property (p_forced_off) else $error("off-time broken");

   property p_two_phase;
      @(posedge ref_clk) disable iff (!reset_n)
      (mode_q == pwm_interleave_pkg::MODE_TWO) |-> !termHit[2] && !termHit[3];
   endproperty
   a_two_phase: assert property (p_two_phase) else $error("extra phase in 2ch");

   property p_three_phase;
      @(posedge ref_clk) disable iff (!reset_n)
      (mode_q == pwm_interleave_pkg::MODE_THREE) |-> !termHit[3];
   endproperty
   a_three_phase: assert property (p_three_phase) else $error("extra phase in 3ch");

   property p_spacing;
      @(posedge ref_clk) disable iff (!reset_n)
      termHit[1] |-> (32'(cnt_q) * 32'(activeChannels) <= 32'(period_q)) &&
                     ((32'(cnt_q) + 1) * 32'(activeChannels) > 32'(period_q));
   endproperty
   a_spacing: assert property (p_spacing) else $error("phase 2 spacing");

   property p_window_open;
      @(posedge ref_clk) disable iff (!reset_n)
      termHit[0] |=> sampleWindow[0];
   endproperty
   a_window_open: assert property (p_window_open) else $error("sample not started");

   property p_off_len;
      @(posedge ref_clk) disable iff (!reset_n)
      termHit[0] |-> (offTime * 3 >= period_q);
   endproperty
   a_off_len: assert property (p_off_len) else $error("off-time short");

   // Length of the present low stretch of phase 1, kept only for the off-time check.
   // It saturates so that a long idle stretch cannot wrap back to a short value.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         lowRun_q <= '0;
      end else if (phaseOut[0]) begin
         lowRun_q <= '0;
      end else if (lowRun_q != '1) begin
         lowRun_q <= lowRun_q + 1'b1;
      end
   end

   property p_off_span;
      @(posedge ref_clk) disable iff (!reset_n)
      $rose(phaseOut[0]) |->
         (32'(lowRun_q) * 32'(pwm_interleave_pkg::OFF_DIVISOR) >= 32'(period_q));
   endproperty
   a_off_span: assert property (p_off_span) else $error("low stretch too short");

   // An output whose pin is not enabled must never be driven high.
   property p_quiet_inactive;
      @(posedge ref_clk) disable iff (!reset_n)
      (phaseOut & ~phaseOutEn) == 4'h0;
   endproperty
   a_quiet_inactive: assert property (p_quiet_inactive) else $error("idle phase high");

   // Main scenarios reached: a cycle, a channel-2 fall, falls in the two- and three-channel counts and a held sample.
   c_cycle: cover property (@(posedge ref_clk) termHit[0]);
   c_fall2: cover property (@(posedge ref_clk) fall[1]);
   c_held: cover property (@(posedge ref_clk) heldValid[3]);
   c_two: cover property (@(posedge ref_clk)
      (activeChannels == pwm_interleave_pkg::CH_TWO) && fall[1]);
   c_three: cover property (@(posedge ref_clk)
      (activeChannels == pwm_interleave_pkg::CH_THREE) && fall[2]);
endmodule // multiphase_pwm_interleave_sampler

// *** shared/pwm_interleave_pkg.sv ***
// Package with timing constants and modes of the interleaved phase timing core.
package pwm_interleave_pkg;
   localparam int unsigned PERIOD_W        = 16;
   localparam int unsigned CUR_W           = 12;
   localparam int unsigned NUM_PHASES      = 4;
   localparam logic [15:0] DEFAULT_PERIOD  = 16'h0064;
   localparam logic [15:0] MIN_PERIOD      = 16'h000C;
   localparam logic [1:0]  MODE_TWO        = 2'h2;
   localparam logic [1:0]  MODE_THREE      = 2'h3;
   localparam logic [1:0]  MODE_FOUR       = 2'h0;
   localparam logic [2:0]  CH_TWO          = 3'h2;
   localparam logic [2:0]  CH_THREE        = 3'h3;
   localparam logic [2:0]  CH_FOUR         = 3'h4;
   localparam logic [2:0]  OFF_DIVISOR     = 3'h3;
   localparam logic [15:0] CLK_PERIOD_NS   = 16'h000A;
endpackage

// *** core/phase_sample_hold.sv ***
// One channel sample-and-hold: window opens on the falling edge and the result is held.
module phase_sample_hold #(
   parameter int unsigned CUR_W    = 12,
   parameter int unsigned PERIOD_W = 16
) (
   input  wire logic                ref_clk,      // System clock.
   input  wire logic                reset_n,      // Asynchronous reset, active low.
   input  wire logic                fallPulse,    // Channel output falling edge, one cycle.
   input  wire logic [PERIOD_W-1:0] windowLen,    // Window length in cycles.
   input  wire logic [CUR_W-1:0]    sensed,       // Live sensed current of the channel.
   output logic                     sampling,     // High while the window is open.
   output logic [CUR_W-1:0]         heldCurrent,  // Held sample of the channel.
   output logic                     heldValid     // One-cycle pulse when a new sample is held.
);
   logic [PERIOD_W-1:0] winCnt_q;
   logic [CUR_W-1:0]    acc_q;

   // Window counter starts at the falling edge and runs for the window length.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         winCnt_q <= '0;
      end else if (fallPulse) begin
         winCnt_q <= windowLen;
      end else if (winCnt_q != '0) begin
         winCnt_q <= winCnt_q - 1'b1;
      end
   end

   assign sampling = (winCnt_q != '0);

   // The tracking value follows the input while the window is open.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_q <= '0;
      end else if (fallPulse || sampling) begin
         acc_q <= sensed;
      end
   end

   // Hold the captured value until the next window of this channel closes.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         heldCurrent <= '0;
         heldValid   <= 1'b0;
      end else begin
         heldValid <= (winCnt_q == 1);
         if (winCnt_q == 1) begin
            heldCurrent <= acc_q;
         end
      end
   end

   property p_window_len;
      @(posedge ref_clk) disable iff (!reset_n)
      fallPulse |=> (winCnt_q == windowLen);
   endproperty
   a_window_len: assert property (p_window_len) else $error("window length wrong");

   property p_hold_stable;
      @(posedge ref_clk) disable iff (!reset_n)
      !$past(winCnt_q == 1) |-> $stable(heldCurrent);
   endproperty
   a_hold_stable: assert property (p_hold_stable) else $error("held value moved");
endmodule // phase_sample_hold

// *** verif/phase_driver_model.sv ***
// Behavioural model of the per-phase driver chips and strap ties at the far side of the core.
module phase_driver_model (
   ref_clk,         // System clock.
   phaseOut,        // Phase drive from the core.
   phaseOutEn,      // Phase pin enables from the core.
   tie3,            // Phase 3 pin tied to supply.
   tie4,            // Phase 4 pin tied to supply.
   phase3TiedHigh,  // Resolved phase 3 pin level.
   phase4TiedHigh,  // Resolved phase 4 pin level.
   sensedCurrent    // Sensed current of each channel.
);
   timeunit 1ns;
   timeprecision 100ps;
   input  wire logic        ref_clk;         // Clock.
   input  wire logic [3:0]  phaseOut;        // Drive.
   input  wire logic [3:0]  phaseOutEn;      // Enables.
   input  wire logic        tie3;            // Tie on phase 3.
   input  wire logic        tie4;            // Tie on phase 4.
   output logic             phase3TiedHigh;  // Pin 3 level.
   output logic             phase4TiedHigh;  // Pin 4 level.
   output logic [47:0]      sensedCurrent;   // Currents.
   logic [3:0] prevOut;
   ////////////////////////////////////////////////////////////////////////////////
   // A tie to the supply overrides whatever the core drives onto the pin.
   assign phase3TiedHigh = tie3 | (phaseOutEn[2] & phaseOut[2]);
   assign phase4TiedHigh = tie4 | (phaseOutEn[3] & phaseOut[3]);
   ////////////////////////////////////////////////////////////////////////////////
   // Each lower switch turn-on brings a new current level, steady until the next one.
   initial begin
      prevOut = 4'h0;
      sensedCurrent = {12'h400, 12'h300, 12'h200, 12'h100};
      forever begin
         @(posedge ref_clk);
         prevOut <= phaseOut;
         for (int k = 0; k < 4; k++) begin
            if (prevOut[k] && !phaseOut[k]) begin
               sensedCurrent[k*12 +: 12] <= sensedCurrent[k*12 +: 12] + 12'(12'h011 * (k + 1));
            end
         end
      end
   end
endmodule // phase_driver_model

// *** verif/multiphase_pwm_interleave_sampler_tb_top.sv ***
// Self-checking testbench of the interleaved phase timing core.
module multiphase_pwm_interleave_sampler_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        ref_clk, reset_n, tie3, tie4, cycleStart, phase3TiedHigh, phase4TiedHigh;
   logic [15:0] freqSet;
   logic [3:0]  phaseDemand, phaseOut, phaseOutEn, sampleWindow, heldValid;
   logic [2:0]  activeChannels;
   logic [47:0] sensedCurrent, heldCurrent;
   int          errorCnt = 0;
   int          checks = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // Clock and time-zero input values.
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      reset_n = 1'b0;
      tie3 = 1'b0;
      tie4 = 1'b0;
      freqSet = pwm_interleave_pkg::DEFAULT_PERIOD;
      phaseDemand = 4'hF;
   end
   multiphase_pwm_interleave_sampler DUT (.ref_clk(ref_clk), .reset_n(reset_n),
      .freq_set_input(freqSet), .phaseDemand(phaseDemand), .phase3TiedHigh(phase3TiedHigh),
      .phase4TiedHigh(phase4TiedHigh), .sensed_current(sensedCurrent), .phaseOut(phaseOut),
      .phaseOutEn(phaseOutEn), .activeChannels(activeChannels), .cycleStart(cycleStart),
      .sampleWindow(sampleWindow), .heldCurrent(heldCurrent), .heldValid(heldValid));
   phase_driver_model drivers (.ref_clk(ref_clk), .phaseOut(phaseOut), .phaseOutEn(phaseOutEn),
      .tie3(tie3), .tie4(tie4), .phase3TiedHigh(phase3TiedHigh),
      .phase4TiedHigh(phase4TiedHigh), .sensedCurrent(sensedCurrent));
   ////////////////////////////////////////////////////////////////////////////////
   // Shared compare, reset and two-period timing measurement.
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errorCnt++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic do_reset(input logic t3, input logic t4, input logic [15:0] p);
      @(negedge ref_clk);
      reset_n = 1'b0;
      tie3 = t3;
      tie4 = t4;
      freqSet = p;
      repeat (20) @(negedge ref_clk);
      reset_n = 1'b1;
   endtask
   task automatic measure(input int p, input int n);
      int fall[4];
      int rise[4];
      int win[4];
      int hv[4];
      int cs;
      int off;
      logic [3:0] prev;
      off = (p + 2) / 3;
      repeat (2) begin
         cs = 0;
         @(negedge ref_clk);
         while (cycleStart !== 1'b1 && cs < 3000) begin
            @(negedge ref_clk);
            cs++;
         end
      end
      cmp(cs < 3000, 1'b1);
      cmp(activeChannels, n);
      cmp(phaseOutEn, (1 << n) - 1);
      prev = phaseOut;
      cs = -1;
      for (int k = 0; k < 4; k++) begin
         fall[k] = -1;
         rise[k] = -1;
         win[k] = 0;
         hv[k] = -1;
      end
      for (int c = 1; c <= 2 * p; c++) begin
         @(negedge ref_clk);
         if (cycleStart === 1'b1 && cs < 0) cs = c;
         for (int k = 0; k < 4; k++) begin
            if (prev[k] === 1'b1 && phaseOut[k] === 1'b0 && fall[k] < 0) begin
               fall[k] = c;
               cmp(sampleWindow[k], 1'b1);
            end
            if (fall[k] >= 0 && rise[k] < 0 && phaseOut[k] === 1'b1) rise[k] = c;
            if (fall[k] >= 0 && c < fall[k] + off + 2 && sampleWindow[k] === 1'b1) win[k]++;
            if (fall[k] >= 0 && hv[k] < 0 && heldValid[k] === 1'b1) hv[k] = c;
            if (heldValid[k] === 1'b1) begin
               cmp(heldCurrent[k*12 +: 12], sensedCurrent[k*12 +: 12]);
            end
         end
         prev = phaseOut;
      end
      cmp(cs, p);
      cmp(fall[0], 1);
      for (int k = 1; k < 4; k++) cmp(fall[k], (k < n) ? k * (p / n) + 1 : -1);
      for (int k = 0; k < n; k++) begin
         cmp(rise[k] - fall[k] >= off, 1'b1);
         cmp(win[k], off);
         cmp(hv[k] - fall[k], off);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios: default four phases, two phases with both ties, three phases, period changes.
   task automatic test_four();
      do_reset(1'b0, 1'b0, pwm_interleave_pkg::DEFAULT_PERIOD);
      measure(100, 4);
   endtask
   task automatic test_two();
      do_reset(1'b1, 1'b1, 16'h003C);
      measure(60, 2);
   endtask
   task automatic test_three();
      do_reset(1'b0, 1'b1, 16'h0030);
      measure(48, 3);
   endtask
   task automatic test_period();
      do_reset(1'b0, 1'b0, 16'h0005);
      measure(12, 4);
      freqSet = 16'h0050;
      measure(80, 4);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Verdict, main sequence and watchdog.
   task automatic end_of_test();
      $display("errors %0d checks %0d", errorCnt, checks);
      if (errorCnt == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      test_four();
      test_two();
      test_three();
      test_period();
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      errorCnt++;
      end_of_test();
   end
endmodule // multiphase_pwm_interleave_sampler_tb_top
